/* File: rtc_link_pkg.sv */
// Shared constants for the two-wire RTC serial front end and its master.
// Assumes both ends run on one core clock of 125 MHz.
package rtc_link_pkg;
  localparam logic [3:0] ID_ARRAY = 4'ha;
  localparam logic [3:0] ID_CTRL = 4'hd;
  localparam logic [2:0] DEV_SELECT = 3'h7;
  localparam int ID_MSB = 7;
  localparam int ID_LSB = 4;
  localparam int SEL_MSB = 3;
  localparam int SEL_LSB = 1;
  localparam int RW_BIT = 0;
  localparam logic [15:0] ADDR_RESET = 16'h0000;
  localparam int BYTE_BITS = 8;
  localparam int CLK_MHZ = 125;
  localparam int SCL_HALF_NS = 40;
  localparam int SCL_HALF_CYC = (SCL_HALF_NS * CLK_MHZ) / 1000;
  localparam int FILT_CYC = 3;
  typedef enum logic [1:0] {TGT_NONE, TGT_ARRAY, TGT_CTRL} target_t;
endpackage : rtc_link_pkg

/* File: rtc_link_if.sv */
// Two-wire bus between the RTC front end and its master.
// Open-drain: each party gives an output and an active-low enable; the wire is pulled high.
`timescale 1ns/1ps
interface rtc_link_if;
  logic scl_o;
  logic scl_oe_n;
  logic sda_m_o;
  logic sda_m_oe_n;
  logic sda_s_o;
  logic sda_s_oe_n;
  wire scl = scl_oe_n ? 1'b1 : scl_o;
  wire sda = (sda_m_oe_n ? 1'b1 : sda_m_o) & (sda_s_oe_n ? 1'b1 : sda_s_o);
  modport device (input scl, input sda, output sda_s_o, output sda_s_oe_n);
  modport master (input scl, input sda, output scl_o, output scl_oe_n, output sda_m_o, output sda_m_oe_n);
endinterface : rtc_link_if

/* File: rtc_i2c_slave_front_end.sv */
// Slave end of the two-wire link: start/stop, address decode, acknowledge, read/write bytes.
// Assumes the bus lines arrive asynchronously and are sampled on CORE_CLK_IN.
//
// Summary of operation
// - Data changes only while clock low
// - Start is data falling, clock high
// - Stop is data rising; returns to standby
// - Master stops only after bus released
// - Receiver acknowledges in the ninth clock
// - Acknowledge address only on matching identifier
// - Acknowledge every written byte
// - Read: send byte, sample acknowledge, continue
// - No acknowledge ends read data output
// - Master stops after withholding acknowledge
// - Top four bits pick array or control
// - Select bits must equal fixed value
// - Lowest bit: one read, zero write
// - Compare seven upper bits, acknowledge match
// - Two word address bytes follow slave byte
// - Address counter clears at power-up
// - Random read reuses the same slave byte
// - Bus disable bit governs battery operation
// - Disabled in battery mode when bit set
// - Ignore bus during nonvolatile write
`timescale 1ns/1ps
module rtc_i2c_slave_front_end (
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  rtc_link_if.device LINK,
  input wire logic BATTERY_MODE_IN,
  input wire logic BATTERY_BUS_DISABLE_BIT_IN,
  input wire logic NV_WRITE_BUSY_IN,
  input wire logic [7:0] RD_DATA_IN,
  output logic [15:0] WORD_ADDR_OUT,
  output logic [1:0] TARGET_OUT,
  output logic [7:0] WR_DATA_OUT,
  output logic WR_STROBE_OUT,
  output logic RD_STROBE_OUT,
  output logic STOP_OUT,
  output logic STANDBY_OUT
);
  import rtc_link_pkg::*;

  typedef enum logic [2:0] {S_IDLE, S_SLAVE, S_ADDR_HI, S_ADDR_LO, S_WDATA, S_RDATA, S_RACK} state_t;

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisers and glitch filter
  logic [1:0] scl_sync_q, sda_sync_q;
  logic scl_f_q, sda_f_q, scl_prev_q, sda_prev_q;
  logic [1:0] scl_cnt_q, sda_cnt_q;

  always_ff @(posedge CORE_CLK_IN) begin
    scl_sync_q <= {scl_sync_q[0], LINK.scl};
    sda_sync_q <= {sda_sync_q[0], LINK.sda};
  end

  // A level must hold FILT_CYC samples before it counts, so spikes shorter than that vanish
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      scl_f_q <= 1'b1;
      sda_f_q <= 1'b1;
      scl_cnt_q <= 2'h0;
      sda_cnt_q <= 2'h0;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_cnt_q <= (scl_sync_q[1] == scl_f_q) ? 2'h0 : scl_cnt_q + 2'h1;
      sda_cnt_q <= (sda_sync_q[1] == sda_f_q) ? 2'h0 : sda_cnt_q + 2'h1;
      if (scl_cnt_q == 2'(FILT_CYC - 1)) scl_f_q <= scl_sync_q[1];
      if (sda_cnt_q == 2'(FILT_CYC - 1)) sda_f_q <= sda_sync_q[1];
      scl_prev_q <= scl_f_q;
      sda_prev_q <= sda_f_q;
    end
  end

  wire scl_rise = scl_f_q & ~scl_prev_q;
  wire scl_fall = ~scl_f_q & scl_prev_q;
  // Data moving while clock high is a bus condition, never data
  wire start_det = scl_f_q & scl_prev_q & sda_prev_q & ~sda_f_q;
  wire stop_det = scl_f_q & scl_prev_q & ~sda_prev_q & sda_f_q;
  wire bus_off = (BATTERY_MODE_IN & BATTERY_BUS_DISABLE_BIT_IN) | NV_WRITE_BUSY_IN;

  ////////////////////////////////////////////////////////////////////////
  // Byte engine
  state_t state_q;
  logic [7:0] shift_q;
  logic [3:0] bit_q;
  logic ack_phase_q, sda_drv_q, read_q, was_read_q;
  logic [1:0] tgt_q;
  logic [15:0] addr_q;
  logic [7:0] wdata_q;
  logic wr_stb_q, rd_stb_q, stop_q;

  wire [7:0] shifted = {shift_q[6:0], sda_f_q};
  wire id_array = shifted[ID_MSB:ID_LSB] == ID_ARRAY;
  wire id_ctrl = shifted[ID_MSB:ID_LSB] == ID_CTRL;
  wire sel_ok = shifted[SEL_MSB:SEL_LSB] == DEV_SELECT;
  wire addr_match = (id_array | id_ctrl) & sel_ok;
  wire byte_done = scl_rise & ~ack_phase_q & (bit_q == 4'(BYTE_BITS - 1));
  wire rx_state = (state_q == S_SLAVE) | (state_q == S_ADDR_HI) | (state_q == S_ADDR_LO) | (state_q == S_WDATA);

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      state_q <= S_IDLE;
      shift_q <= 8'h00;
      bit_q <= 4'h0;
      ack_phase_q <= 1'b0;
      sda_drv_q <= 1'b0;
      read_q <= 1'b0;
      was_read_q <= 1'b0;
      tgt_q <= TGT_NONE;
      addr_q <= ADDR_RESET;
      wdata_q <= 8'h00;
      wr_stb_q <= 1'b0;
      rd_stb_q <= 1'b0;
      stop_q <= 1'b0;
    end else begin
      wr_stb_q <= 1'b0;
      rd_stb_q <= 1'b0;
      stop_q <= 1'b0;
      if (stop_det) begin
        state_q <= S_IDLE;
        sda_drv_q <= 1'b0;
        stop_q <= 1'b1;
        was_read_q <= 1'b0;
      end else if (start_det && !bus_off) begin
        state_q <= S_SLAVE;
        bit_q <= 4'h0;
        ack_phase_q <= 1'b0;
        sda_drv_q <= 1'b0;
      end else if (start_det) begin
        state_q <= S_IDLE;
        sda_drv_q <= 1'b0;
      end else if (state_q != S_IDLE) begin
        if (rx_state && scl_rise && !ack_phase_q) begin
          shift_q <= shifted;
          bit_q <= bit_q + 4'h1;
        end
        if (state_q == S_RDATA && scl_rise && !ack_phase_q) bit_q <= bit_q + 4'h1;
        if (byte_done) begin
          ack_phase_q <= 1'b1;
          bit_q <= 4'h0;
          case (state_q)
            S_SLAVE: begin
              if (!addr_match) state_q <= S_IDLE;
              else begin
                tgt_q <= id_array ? TGT_ARRAY : TGT_CTRL;
                // Stay here until our acknowledge ends, so the slot is driven in either direction
                read_q <= shifted[RW_BIT];
              end
            end
            S_ADDR_HI: addr_q[15:8] <= shifted;
            S_ADDR_LO: addr_q[7:0] <= shifted;
            S_WDATA: begin
              wdata_q <= shifted;
              wr_stb_q <= 1'b1;
            end
            default: ;
          endcase
        end
        if (scl_fall && ack_phase_q && bit_q == 4'h0 && !sda_drv_q && state_q != S_RDATA && state_q != S_RACK) begin
          sda_drv_q <= 1'b1;
        end
        // Last read bit holds until the clock falls; releasing at the rise would look like a stop
        if (state_q == S_RDATA && scl_fall && ack_phase_q) begin
          state_q <= S_RACK;
          shift_q <= 8'hff;
        end
        // Master acknowledge slot of a read: sample on the ninth rise, load the next byte at the fall
        if (state_q == S_RACK && scl_rise && ack_phase_q) begin
          ack_phase_q <= 1'b0;
          if (sda_f_q) state_q <= S_IDLE;
          else addr_q <= addr_q + 16'h1;
        end
        if (state_q == S_RACK && scl_fall && !ack_phase_q) begin
          state_q <= S_RDATA;
          shift_q <= RD_DATA_IN;
          rd_stb_q <= 1'b1;
          was_read_q <= 1'b1;
        end
        // End of our acknowledge: release and move on
        if (scl_fall && ack_phase_q && sda_drv_q) begin
          sda_drv_q <= 1'b0;
          ack_phase_q <= 1'b0;
          case (state_q)
            S_SLAVE: begin
              state_q <= read_q ? S_RDATA : S_ADDR_HI;
              if (read_q) begin
                shift_q <= RD_DATA_IN;
                rd_stb_q <= 1'b1;
                was_read_q <= 1'b1;
              end
            end
            S_ADDR_HI: state_q <= S_ADDR_LO;
            S_ADDR_LO: state_q <= S_WDATA;
            S_WDATA: addr_q <= addr_q + 16'h1;
            default: ;
          endcase
        end
        // Drive read bits while clock low, from the shift register MSB
        if (state_q == S_RDATA && scl_fall && !ack_phase_q && bit_q != 4'h0) shift_q <= {shift_q[6:0], 1'b1};
      end
    end
  end

  // Our pull-down: acknowledge slots, and read data zeros in S_RDATA
  wire read_drive = (state_q == S_RDATA) & ~shift_q[7] & ~bus_off;

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      LINK.sda_s_oe_n <= 1'b1;
    end else begin
      LINK.sda_s_oe_n <= ~((sda_drv_q & ~bus_off) | read_drive);
    end
  end
  always_ff @(posedge CORE_CLK_IN) LINK.sda_s_o <= 1'b0;

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      WORD_ADDR_OUT <= ADDR_RESET;
      TARGET_OUT <= TGT_NONE;
      WR_DATA_OUT <= 8'h00;
      WR_STROBE_OUT <= 1'b0;
      RD_STROBE_OUT <= 1'b0;
      STOP_OUT <= 1'b0;
      STANDBY_OUT <= 1'b1;
    end else begin
      WORD_ADDR_OUT <= addr_q;
      TARGET_OUT <= tgt_q;
      WR_DATA_OUT <= wdata_q;
      WR_STROBE_OUT <= wr_stb_q;
      RD_STROBE_OUT <= rd_stb_q;
      STOP_OUT <= stop_q;
      STANDBY_OUT <= state_q == S_IDLE;
    end
  end
endmodule : rtc_i2c_slave_front_end

/* File: rtc_i2c_master_end.sv */
// Master end of the two-wire link: generates clock, start, stop, bytes and acknowledge.
// Assumes a single core clock; the bus clock is a divided copy driven out open-drain.
`timescale 1ns/1ps
module rtc_i2c_master_end (
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  rtc_link_if.master LINK,
  input wire logic CMD_START_IN,
  input wire logic CMD_STOP_IN,
  input wire logic CMD_WRITE_IN,
  input wire logic CMD_READ_IN,
  input wire logic CMD_ACK_IN,
  input wire logic [7:0] CMD_DATA_IN,
  output logic BUSY_OUT,
  output logic DONE_OUT,
  output logic ACK_SEEN_OUT,
  output logic [7:0] RX_DATA_OUT
);
  import rtc_link_pkg::*;

  typedef enum logic [2:0] {M_IDLE, M_START, M_BIT, M_ACK, M_STOP} mstate_t;

  ////////////////////////////////////////////////////////////////////////
  logic [1:0] sda_sync_q;
  mstate_t st_q;
  logic [7:0] div_q;
  logic [1:0] phase_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic rd_q, ack_q, scl_low_q, sda_low_q;

  always_ff @(posedge CORE_CLK_IN) sda_sync_q <= {sda_sync_q[0], LINK.sda};

  wire tick = div_q == 8'(SCL_HALF_CYC - 1);

  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      st_q <= M_IDLE;
      div_q <= 8'h00;
      phase_q <= 2'h0;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      rd_q <= 1'b0;
      ack_q <= 1'b0;
      scl_low_q <= 1'b0;
      sda_low_q <= 1'b0;
      BUSY_OUT <= 1'b0;
      DONE_OUT <= 1'b0;
      ACK_SEEN_OUT <= 1'b0;
      RX_DATA_OUT <= 8'h00;
    end else begin
      DONE_OUT <= 1'b0;
      div_q <= tick ? 8'h00 : div_q + 8'h1;
      if (st_q == M_IDLE) begin
        div_q <= 8'h00;
        phase_q <= 2'h0;
        BUSY_OUT <= 1'b0;
        if (CMD_START_IN) st_q <= M_START;
        else if (CMD_STOP_IN) st_q <= M_STOP;
        else if (CMD_WRITE_IN || CMD_READ_IN) begin
          st_q <= M_BIT;
          sh_q <= CMD_READ_IN ? 8'hff : CMD_DATA_IN;
          rd_q <= CMD_READ_IN;
          ack_q <= CMD_ACK_IN;
          bit_q <= 4'h0;
        end
        if (CMD_START_IN || CMD_STOP_IN || CMD_WRITE_IN || CMD_READ_IN) BUSY_OUT <= 1'b1;
      end else if (tick) begin
        phase_q <= phase_q + 2'h1;
        case (st_q)
          // Repeated start safe: data high, clock high, then data low
          M_START: begin
            case (phase_q)
              2'h0: sda_low_q <= 1'b0;
              2'h1: scl_low_q <= 1'b0;
              2'h2: sda_low_q <= 1'b1;
              default: begin
                scl_low_q <= 1'b1;
                st_q <= M_IDLE;
                DONE_OUT <= 1'b1;
              end
            endcase
          end
          M_BIT, M_ACK: begin
            case (phase_q)
              2'h0: begin
                scl_low_q <= 1'b1;
                // Data only changes while clock is low
                if (st_q == M_BIT) sda_low_q <= ~sh_q[7];
                else sda_low_q <= rd_q ? ack_q : 1'b0;
              end
              2'h1: scl_low_q <= 1'b0;
              2'h2: begin
                if (st_q == M_BIT) sh_q <= {sh_q[6:0], sda_sync_q[1]};
                else ACK_SEEN_OUT <= ~sda_sync_q[1];
              end
              default: begin
                scl_low_q <= 1'b1;
                phase_q <= 2'h0;
                if (st_q == M_BIT) begin
                  bit_q <= bit_q + 4'h1;
                  if (bit_q == 4'(BYTE_BITS - 1)) st_q <= M_ACK;
                end else begin
                  sda_low_q <= 1'b0;
                  RX_DATA_OUT <= sh_q;
                  st_q <= M_IDLE;
                  DONE_OUT <= 1'b1;
                end
              end
            endcase
          end
          M_STOP: begin
            case (phase_q)
              2'h0: sda_low_q <= 1'b1;
              2'h1: scl_low_q <= 1'b0;
              2'h2: sda_low_q <= 1'b0;
              default: begin
                st_q <= M_IDLE;
                DONE_OUT <= 1'b1;
              end
            endcase
          end
          default: st_q <= M_IDLE;
        endcase
      end
    end
  end

  // Open drain: only ever pull low, release otherwise (enable low = drive)
  always_ff @(posedge CORE_CLK_IN) begin
    if (SYS_RST_IN) begin
      LINK.scl_oe_n <= 1'b1;
      LINK.sda_m_oe_n <= 1'b1;
    end else begin
      LINK.scl_oe_n <= ~scl_low_q;
      LINK.sda_m_oe_n <= ~sda_low_q;
    end
  end
  always_ff @(posedge CORE_CLK_IN) begin
    LINK.scl_o <= 1'b0;
    LINK.sda_m_o <= 1'b0;
  end
endmodule : rtc_i2c_master_end

/* File: rtc_i2c_slave_front_end_sva.sv */
// Link checker for the slave front end and its master, joined by rtc_link_if.
// Assumes it watches the resolved wires and the two data-line open-drain enables of that interface.
`timescale 1ns/1ps
module rtc_i2c_slave_front_end_sva
  import rtc_link_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic scl,
  input wire logic sda,
  input wire logic sda_s_oe_n,
  input wire logic sda_m_oe_n
);
  logic scl_q, sda_q, act_q, first_q, rd_q, wr_q, nack_q;
  logic [3:0] cnt_q;
  logic [6:0] sh_q, id_q;
  wire rise_w = scl && !scl_q;
  wire start_w = scl && scl_q && sda_q && !sda;
  wire stop_w = scl && scl_q && !sda_q && sda;
  wire slot_w = rise_w && act_q && (cnt_q == 4'h8);
  ////////////////////////////////////////////////////////////////////////////////
  // Bit position inside a frame, counted on wire clock rises
  always_ff @(posedge CORE_CLK_IN) begin
    scl_q <= scl;
    sda_q <= sda;
    if (SYS_RST_IN || start_w || stop_w) begin
      act_q <= start_w && !SYS_RST_IN;
      cnt_q <= 4'h0;
      first_q <= 1'b1;
      nack_q <= 1'b0;
      wr_q <= 1'b0;
    end else if (rise_w && act_q) begin
      sh_q <= {sh_q[5:0], sda};
      cnt_q <= (cnt_q == 4'h8) ? 4'h0 : cnt_q + 4'h1;
      if (first_q && cnt_q == 4'h7) begin
        id_q <= sh_q;
        rd_q <= sda;
      end
      if (slot_w) begin
        first_q <= 1'b0;
        wr_q <= first_q ? (!rd_q && !sda_s_oe_n) : wr_q;
        nack_q <= nack_q || (!first_q && rd_q && sda);
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  AST_ADDR_MATCH: assert property (slot_w && first_q && !sda_s_oe_n |->
    (id_q == {ID_ARRAY, DEV_SELECT}) || (id_q == {ID_CTRL, DEV_SELECT})) else $error("ack on foreign address");
  AST_WRITE_ACK: assert property (slot_w && !first_q && wr_q |-> !sda_s_oe_n)
    else $error("written byte not acknowledged");
  AST_READ_RELEASE: assert property (slot_w && !first_q && rd_q |-> sda_s_oe_n)
    else $error("slave holds data in ack slot");
  AST_NACK_QUIET: assert property (nack_q |-> sda_s_oe_n) else $error("read data after no ack");
  AST_IDLE_QUIET: assert property (!act_q |-> sda_s_oe_n) else $error("slave pulls outside a frame");
  AST_NO_CLASH: assert property (scl && scl_q |-> sda_s_oe_n || sda_m_oe_n)
    else $error("both ends pull data with clock high");
  AST_SDA_SCL_LOW: assert property ($changed(sda_s_oe_n) |-> !scl)
    else $error("slave moves data with clock high");
  AST_STOP_QUIET: assert property (stop_w |=> sda_s_oe_n [*8])
    else $error("slave active after stop");
  cover property (slot_w && first_q && !sda_s_oe_n);
  cover property (slot_w && !first_q && wr_q);
  cover property (nack_q && stop_w);
endmodule : rtc_i2c_slave_front_end_sva

/* File: tb_rtc_i2c_slave_front_end.sv */
// Bench joining the master end and the slave front end over one link.
// Assumes ack_seen high means the slave pulled the ack slot.
`timescale 1ns/1ps
module tb_rtc_i2c_slave_front_end;
  import rtc_link_pkg::*;
  localparam logic [3:0] K_START = 4'h8, K_STOP = 4'h4, K_WR = 4'h2, K_RD = 4'h1;
  logic clk = 1'b0, rst = 1'b1;
  logic c_start = 1'b0, c_stop = 1'b0, c_wr = 1'b0, c_rd = 1'b0, c_ack = 1'b0;
  logic bat = 1'b0, bbd = 1'b0, nvb = 1'b0;
  logic [7:0] c_data = 8'h00, rd_data = 8'h00, rx, wdata;
  logic busy, done, ack_seen, wr_stb, rd_stb, stop_p, stby;
  logic [15:0] waddr;
  logic [1:0] tgt;
  logic [7:0] rtab [0:7];
  logic [2:0] rd_ptr = 3'h0;
  logic [7:0] wq [$];
  int bad_count = 0, num_checks = 0;
  rtc_link_if link ();
  rtc_i2c_master_end i_rtc_i2c_master_end (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .LINK(link),
    .CMD_START_IN(c_start), .CMD_STOP_IN(c_stop), .CMD_WRITE_IN(c_wr), .CMD_READ_IN(c_rd), .CMD_ACK_IN(c_ack),
    .CMD_DATA_IN(c_data), .BUSY_OUT(busy), .DONE_OUT(done), .ACK_SEEN_OUT(ack_seen), .RX_DATA_OUT(rx));
  rtc_i2c_slave_front_end i_rtc_i2c_slave_front_end (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .LINK(link),
    .BATTERY_MODE_IN(bat), .BATTERY_BUS_DISABLE_BIT_IN(bbd), .NV_WRITE_BUSY_IN(nvb), .RD_DATA_IN(rd_data),
    .WORD_ADDR_OUT(waddr), .TARGET_OUT(tgt), .WR_DATA_OUT(wdata), .WR_STROBE_OUT(wr_stb),
    .RD_STROBE_OUT(rd_stb), .STOP_OUT(stop_p), .STANDBY_OUT(stby));
  rtc_i2c_slave_front_end_sva i_rtc_i2c_slave_front_end_sva (.CORE_CLK_IN(clk), .SYS_RST_IN(rst),
    .scl(link.scl), .sda(link.sda), .sda_s_oe_n(link.sda_s_oe_n), .sda_m_oe_n(link.sda_m_oe_n));
  initial begin
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Capture written bytes; feed the next read byte once the slave has loaded one
  always @(posedge clk) begin
    if (wr_stb === 1'b1) begin
      wq.push_back(wdata);
    end
    if (rd_stb === 1'b1) begin
      rd_ptr <= rd_ptr + 3'h1;
      rd_data <= rtab[rd_ptr + 3'h1];
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude;
    $display("counts: %0d mismatches in %0d checks", bad_count, num_checks);
    if (bad_count == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_val
  task automatic guard(input int n);
    if (n == 400) begin
      bad_count++;
      conclude();
    end
  endtask : guard
  // Commands are taken only with busy low; the next one waits for done
  task automatic mcmd(input logic [3:0] k, input logic [7:0] d, input logic a);
    int n;
    for (n = 0; busy !== 1'b0; n++) begin
      guard(n);
      @(posedge clk);
    end
    {c_start, c_stop, c_wr, c_rd} <= k;
    c_data <= d;
    c_ack <= a;
    @(posedge clk);
    {c_start, c_stop, c_wr, c_rd} <= 4'h0;
    for (n = 0; done !== 1'b1; n++) begin
      guard(n);
      @(posedge clk);
    end
  endtask : mcmd
  task automatic wbyte(input logic [7:0] d, input logic e);
    mcmd(K_WR, d, 1'b0);
    chk_val(ack_seen, e);
  endtask : wbyte
  task automatic rbyte(input logic [7:0] e, input logic a);
    mcmd(K_RD, 8'h00, a);
    chk_val(rx, e);
  endtask : rbyte
  task automatic arm;
    for (int i = 0; i < 8; i++) begin
      rtab[i] = 8'($urandom);
    end
    rd_ptr <= 3'h0;
    rd_data <= rtab[0];
    @(posedge clk);
  endtask : arm
  function automatic logic exp_ack(input logic [7:0] sa, input logic nv, input logic b, input logic dis);
    return (sa[7:1] == {ID_ARRAY, DEV_SELECT} || sa[7:1] == {ID_CTRL, DEV_SELECT}) && !nv && !(b && dis);
  endfunction : exp_ack
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int i, j, n;
    logic [7:0] sa, ah, al;
    void'($urandom(40668));
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (20) @(posedge clk);
    chk_val(waddr, ADDR_RESET);
    chk_val(stby, 1'b1);
    arm();
    mcmd(K_START, 8'h00, 1'b0);
    wbyte({ID_ARRAY, DEV_SELECT, 1'b1}, 1'b1);
    chk_val(tgt, TGT_ARRAY);
    rbyte(rtab[0], 1'b0);
    mcmd(K_STOP, 8'h00, 1'b0);
    repeat (20) @(posedge clk);
    chk_val(stby, 1'b1);
    for (i = 0; i < 4; i++) begin
      arm();
      {ah, al} = 16'($urandom);
      n = 1 + int'($urandom % 3);
      wq.delete();
      mcmd(K_START, 8'h00, 1'b0);
      wbyte({i[0] ? ID_CTRL : ID_ARRAY, DEV_SELECT, 1'b0}, 1'b1);
      chk_val(tgt, i[0] ? TGT_CTRL : TGT_ARRAY);
      wbyte(ah, 1'b1);
      wbyte(al, 1'b1);
      for (j = 0; j < n; j++) begin
        wbyte(rtab[j], 1'b1);
      end
      mcmd(K_STOP, 8'h00, 1'b0);
      repeat (20) @(posedge clk);
      chk_val(waddr, {ah, al} + 16'(n));
      chk_val(16'(wq.size()), 16'(n));
      for (j = 0; j < n; j++) begin
        chk_val(wq[j], rtab[j]);
      end
    end
    arm();
    mcmd(K_START, 8'h00, 1'b0);
    wbyte({ID_ARRAY, DEV_SELECT, 1'b0}, 1'b1);
    wbyte(ah, 1'b1);
    wbyte(al, 1'b1);
    mcmd(K_START, 8'h00, 1'b0);
    wbyte({ID_ARRAY, DEV_SELECT, 1'b1}, 1'b1);
    rbyte(rtab[0], 1'b1);
    rbyte(rtab[1], 1'b1);
    rbyte(rtab[2], 1'b0);
    mcmd(K_STOP, 8'h00, 1'b0);
    repeat (20) @(posedge clk);
    chk_val(waddr, {ah, al} + 16'h0002);
    for (i = 0; i < 7; i++) begin
      sa = {(i == 0) ? 4'h5 : ID_CTRL, (i == 1) ? 3'h3 : DEV_SELECT, 1'b0};
      if (i == 2) begin
        // Write direction only: a matching read would leave the slave driving data into the stop
        sa = {7'($urandom), 1'b0};
      end
      nvb <= (i == 3);
      bat <= (i == 4 || i == 5);
      bbd <= (i == 4 || i == 6);
      repeat (4) @(posedge clk);
      mcmd(K_START, 8'h00, 1'b0);
      wbyte(sa, exp_ack(sa, nvb, bat, bbd));
      mcmd(K_STOP, 8'h00, 1'b0);
      nvb <= 1'b0;
      bat <= 1'b0;
      bbd <= 1'b0;
      repeat (20) @(posedge clk);
    end
    conclude();
  end
endmodule : tb_rtc_i2c_slave_front_end
